// File: src/amd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Arithmetic and logic use register direct only
// - Listed byte ops also accept immediate mode
// - Transfers allow all modes except PC-relative, memory indirect
// - Bit ops: register, indirect, absolute; 3-bit bit
// - Set/clear/invert/test may take bit from register
// - Fifty-five instructions in eight groups
// - Push equals word store with predecrement stack
// - Pop equals word load with postincrement stack
// - Short absolute mode allowed for byte only in transfer and bit ops
// - Transfer: reg-reg, reg-memory, immediate to register
// - Conditional branch carries a condition field
// - Shift group holds eight instructions
// - Branch group holds five instructions
// - System control group holds eight instructions
// - Word access and fetch clear address bit0
// - Short absolute upper byte is all ones
module amd_decoder
  import amd_pkg::*;
(
  input  wire logic     sys_clk,    // 20 MHz clock
  input  wire logic     sys_rst,    // Synchronous reset, high
  input  wire logic     req_valid,  // Request from fetch stage
  input  wire amd_req_t req_in,     // Instruction fields
  output amd_dec_t      dec_out,    // Registered decode result
  output logic          dec_valid   // Result valid, one cycle
);

  amd_req_t          canon;
  logic              legal;
  logic [ADDR_W-1:0] ea;
  amd_dec_t          dec_reg;
  amd_dec_t          dec_next;
  logic              valid_reg;

  function automatic amd_group_t group_of(input amd_op_t op);
    if (op == AMD_OP_GENERAL_TRANSFER) begin
      return AMD_GRP_XFER;
    end else if (op <= AMD_OP_NEG) begin
      return AMD_GRP_ARITH;
    end else if (op <= AMD_OP_NOT) begin
      return AMD_GRP_LOGIC;
    end else if (op <= AMD_OP_ROTATE_RIGHT_CARRY) begin
      return AMD_GRP_SHIFT;
    end else if (op <= AMD_OP_BIST) begin
      return AMD_GRP_BIT;
    end else if (op <= AMD_OP_RETURN_SUB) begin
      return AMD_GRP_BRAN;
    end else if (op <= AMD_OP_NOP) begin
      return AMD_GRP_SYS;
    end else begin
      return AMD_GRP_BLOCK;
    end
  endfunction

  // Stack aliases become word_transfer on the stack register, so the rest of the core sees one form
  wire is_push = (req_in.op == AMD_OP_PUSH_ALIAS);
  wire is_pop  = (req_in.op == AMD_OP_POP_ALIAS);
  always_comb begin
    canon = req_in;
    if (is_push) begin
      canon.op      = AMD_OP_GENERAL_TRANSFER;
      canon.mode    = AMD_AM_INCDEC;
      canon.sub     = AMD_SUB_PRE;
      canon.word    = 1'b1;
      canon.reg_idx = STACK_REG_IDX;
    end else if (is_pop) begin
      canon.op      = AMD_OP_GENERAL_TRANSFER;
      canon.mode    = AMD_AM_INCDEC;
      canon.sub     = AMD_SUB_POST;
      canon.word    = 1'b1;
      canon.reg_idx = STACK_REG_IDX;
    end
  end

  amd_legal_check u_legal (
    .req   (canon),
    .legal (legal)
  );

  amd_ea_form u_ea (
    .req (canon),
    .ea  (ea)
  );

  always_comb begin
    dec_next.op           = canon.op;
    dec_next.group        = group_of(canon.op);
    dec_next.mode         = canon.mode;
    dec_next.sub          = canon.sub;
    dec_next.word         = canon.word;
    dec_next.bit_from_reg = canon.bit_from_reg;
    dec_next.reg_idx      = canon.reg_idx;
    dec_next.bit_imm      = canon.bit_imm;
    dec_next.cond         = (canon.op == AMD_OP_COND_BRANCH) ? canon.cond : 4'h0;
    dec_next.ea           = ea;
    dec_next.invalid      = ~legal;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dec_reg   <= '0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= req_valid;
      if (req_valid) begin
        dec_reg <= dec_next;
      end
    end
  end

  assign dec_out   = dec_reg;
  assign dec_valid = valid_reg;

  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  alu_reg_only_a: assert property ((req_valid && (req_in.op >= AMD_OP_ADD) && (req_in.op <= AMD_OP_ROTATE_RIGHT_CARRY) &&
    (req_in.mode != AMD_AM_REG) && (req_in.mode != AMD_AM_IMM)) |=> dec_out.invalid)
    else $error("alu op with non-register mode not flagged");
  imm_byte_ok_a: assert property ((req_valid && (req_in.op == AMD_OP_ADD_WITH_CARRY) && (req_in.mode == AMD_AM_IMM) &&
    !req_in.word) |=> !dec_out.invalid)
    else $error("immediate add with carry wrongly rejected");
  imm_sub_bad_a: assert property ((req_valid && (req_in.op == AMD_OP_SUB) && (req_in.mode == AMD_AM_IMM)) |=>
    dec_out.invalid)
    else $error("immediate subtract accepted");
  xfer_pcrel_a: assert property ((req_valid && (req_in.op == AMD_OP_GENERAL_TRANSFER) &&
    ((req_in.mode == AMD_AM_PCREL) || (req_in.mode == AMD_AM_MEMIND))) |=> dec_out.invalid)
    else $error("transfer with relative or indirect mode accepted");
  bit_mode_a: assert property ((req_valid && (req_in.op == AMD_OP_BAND) && req_in.bit_from_reg) |=>
    dec_out.invalid)
    else $error("register bit number accepted for bit and");
  push_map_a: assert property ((req_valid && is_push) |=> (dec_out.op == AMD_OP_GENERAL_TRANSFER) &&
    (dec_out.sub == AMD_SUB_PRE) && dec_out.word && (dec_out.reg_idx == STACK_REG_IDX) && !dec_out.invalid)
    else $error("push not mapped to predecrement word store");
  pop_map_a: assert property ((req_valid && is_pop) |=> (dec_out.op == AMD_OP_GENERAL_TRANSFER) &&
    (dec_out.sub == AMD_SUB_POST) && dec_out.word && (dec_out.reg_idx == STACK_REG_IDX))
    else $error("pop not mapped to postincrement word load");
  short_word_a: assert property ((req_valid && (req_in.op == AMD_OP_GENERAL_TRANSFER) && (req_in.mode == AMD_AM_ABS) &&
    (req_in.sub == AMD_SUB_SHORT) && req_in.word) |=> dec_out.invalid)
    else $error("word size with short absolute accepted");
  short_upper_a: assert property ((req_valid && (req_in.mode == AMD_AM_ABS) && (req_in.sub == AMD_SUB_SHORT)) |=>
    (dec_out.ea[15:8] == SHORT_ABS_UPPER))
    else $error("short absolute upper byte not all ones");
  word_even_a: assert property ((dec_valid && dec_out.word) |-> !dec_out.ea[0])
    else $error("word access on odd address");
  cond_kept_a: assert property ((req_valid && (req_in.op == AMD_OP_COND_BRANCH)) |=>
    (dec_out.cond == $past(req_in.cond)) && (dec_out.group == AMD_GRP_BRAN))
    else $error("branch condition lost");
  valid_pulse_a: assert property (req_valid |=> dec_valid)
    else $error("decode result did not follow request");

  push_cov_c: cover property (req_valid && is_push ##1 dec_valid);
  short_cov_c: cover property (req_valid && (req_in.sub == AMD_SUB_SHORT) ##1 !dec_out.invalid);
  bad_cov_c: cover property (req_valid ##1 dec_out.invalid);

endmodule
`default_nettype wire

// File: src/amd_pkg.sv
package amd_pkg;

  localparam int ADDR_W = 16;
  localparam int GREG_N = 8;
  localparam logic [2:0] STACK_REG_IDX = 3'h7;
  localparam logic [7:0] SHORT_ABS_UPPER = 8'hff;
  localparam logic [7:0] MEM_IND_UPPER = 8'h00;
  localparam int INSN_TOTAL = 55;
  localparam int SHIFT_COUNT = 8;
  localparam int BRANCH_COUNT = 5;
  localparam int SYSCTL_COUNT = 8;

  // Addressing mode numbers
  typedef enum logic [3:0] {
    AMD_AM_REG     = 4'h1,
    AMD_AM_IND     = 4'h2,
    AMD_AM_DISP    = 4'h3,
    AMD_AM_INCDEC  = 4'h4,
    AMD_AM_ABS     = 4'h5,
    AMD_AM_IMM     = 4'h6,
    AMD_AM_PCREL   = 4'h7,
    AMD_AM_MEMIND  = 4'h8
  } amd_mode_t;

  // Variant of mode 4 or mode 5
  typedef enum logic [1:0] {
    AMD_SUB_NONE  = 2'h0,
    AMD_SUB_PRE   = 2'h1,
    AMD_SUB_POST  = 2'h2,
    AMD_SUB_SHORT = 2'h3
  } amd_sub_t;

  typedef enum logic [2:0] {
    AMD_GRP_XFER  = 3'h0,
    AMD_GRP_ARITH = 3'h1,
    AMD_GRP_LOGIC = 3'h2,
    AMD_GRP_SHIFT = 3'h3,
    AMD_GRP_BIT   = 3'h4,
    AMD_GRP_BRAN  = 3'h5,
    AMD_GRP_SYS   = 3'h6,
    AMD_GRP_BLOCK = 3'h7
  } amd_group_t;

  // Opcodes: 55 instructions plus stack aliases that map onto word_transfer
  typedef enum logic [5:0] {
    AMD_OP_GENERAL_TRANSFER = 6'h00,
    AMD_OP_ADD       = 6'h01, AMD_OP_SUB         = 6'h02,
    AMD_OP_ADD_WITH_CARRY   = 6'h03, AMD_OP_SUBTRACT_WITH_CARRY = 6'h04,
    AMD_OP_INC       = 6'h05, AMD_OP_DEC         = 6'h06,
    AMD_OP_ADDS      = 6'h07, AMD_OP_SUBS        = 6'h08,
    AMD_OP_DAA       = 6'h09, AMD_OP_DAS         = 6'h0a,
    AMD_OP_MULXU     = 6'h0b, AMD_OP_DIVXU       = 6'h0c,
    AMD_OP_CMP       = 6'h0d, AMD_OP_NEG         = 6'h0e,
    AMD_OP_AND       = 6'h0f, AMD_OP_OR          = 6'h10,
    AMD_OP_XOR       = 6'h11, AMD_OP_NOT         = 6'h12,
    AMD_OP_ARITH_SHIFT_LEFT = 6'h13, AMD_OP_ARITH_SHIFT_RIGHT = 6'h14,
    AMD_OP_LOGIC_SHIFT_LEFT = 6'h15, AMD_OP_LOGIC_SHIFT_RIGHT = 6'h16,
    AMD_OP_ROTATE_LEFT      = 6'h17, AMD_OP_ROTATE_RIGHT      = 6'h18,
    AMD_OP_ROTATE_LEFT_CARRY = 6'h19, AMD_OP_ROTATE_RIGHT_CARRY = 6'h1a,
    AMD_OP_BIT_SET_OP    = 6'h1b, AMD_OP_BIT_CLEAR_OP  = 6'h1c,
    AMD_OP_BIT_INVERT_OP = 6'h1d, AMD_OP_BIT_TEST_OP   = 6'h1e,
    AMD_OP_BAND   = 6'h1f, AMD_OP_BIAND  = 6'h20, AMD_OP_BOR   = 6'h21,
    AMD_OP_BIOR   = 6'h22, AMD_OP_BXOR   = 6'h23, AMD_OP_BIXOR = 6'h24,
    AMD_OP_BLD    = 6'h25, AMD_OP_BILD   = 6'h26, AMD_OP_BST   = 6'h27,
    AMD_OP_BIST   = 6'h28,
    AMD_OP_COND_BRANCH     = 6'h29, AMD_OP_JUMP_OP       = 6'h2a,
    AMD_OP_BRANCH_SUBROUTINE = 6'h2b, AMD_OP_JUMP_SUBROUTINE = 6'h2c,
    AMD_OP_RETURN_SUB      = 6'h2d,
    AMD_OP_RETURN_EXCEPTION = 6'h2e, AMD_OP_SLEEP        = 6'h2f,
    AMD_OP_LOAD_COND_REG   = 6'h30, AMD_OP_STORE_COND_REG = 6'h31,
    AMD_OP_AND_COND_REG    = 6'h32, AMD_OP_OR_COND_REG    = 6'h33,
    AMD_OP_XOR_COND_REG    = 6'h34, AMD_OP_NOP           = 6'h35,
    AMD_OP_BLOCK_TRANSFER_OP = 6'h36,
    AMD_OP_PUSH_ALIAS      = 6'h37,
    AMD_OP_POP_ALIAS       = 6'h38
  } amd_op_t;

  localparam logic [5:0] AMD_OP_LAST_REAL = 6'h36;

  typedef struct packed {
    amd_op_t         op;
    amd_mode_t       mode;
    amd_sub_t        sub;
    logic            word;
    logic            bit_from_reg;
    logic [2:0]      reg_idx;
    logic [2:0]      bit_imm;
    logic [3:0]      cond;
    logic [ADDR_W-1:0] addr_raw;
  } amd_req_t;

  typedef struct packed {
    amd_op_t         op;
    amd_group_t      group;
    amd_mode_t       mode;
    amd_sub_t        sub;
    logic            word;
    logic            bit_from_reg;
    logic [2:0]      reg_idx;
    logic [2:0]      bit_imm;
    logic [3:0]      cond;
    logic [ADDR_W-1:0] ea;
    logic            invalid;
  } amd_dec_t;

endpackage

// File: src/amd_legal_check.sv
`timescale 1ns/1ps
`default_nettype none
module amd_legal_check
  import amd_pkg::*;
(
  input  wire amd_req_t req,      // Canonical request
  output logic          legal     // Combination is allowed
);

  wire is_arith = (req.op >= AMD_OP_ADD) && (req.op <= AMD_OP_NEG);
  wire is_logic = (req.op >= AMD_OP_AND) && (req.op <= AMD_OP_NOT);
  wire is_shift = (req.op >= AMD_OP_ARITH_SHIFT_LEFT) && (req.op <= AMD_OP_ROTATE_RIGHT_CARRY);
  wire is_bit   = (req.op >= AMD_OP_BIT_SET_OP) && (req.op <= AMD_OP_BIST);
  wire is_bset4 = (req.op >= AMD_OP_BIT_SET_OP) && (req.op <= AMD_OP_BIT_TEST_OP);
  wire is_xfer  = (req.op == AMD_OP_GENERAL_TRANSFER);
  wire imm_ok   = (req.op == AMD_OP_ADD) || (req.op == AMD_OP_ADD_WITH_CARRY) ||
                  (req.op == AMD_OP_SUBTRACT_WITH_CARRY) || (req.op == AMD_OP_AND) ||
                  (req.op == AMD_OP_OR) || (req.op == AMD_OP_XOR) ||
                  ((req.op == AMD_OP_CMP) && !req.word);
  wire sp_incdec = (req.mode == AMD_AM_INCDEC) && (req.reg_idx == STACK_REG_IDX);
  wire short_abs = (req.mode == AMD_AM_ABS) && (req.sub == AMD_SUB_SHORT);

  wire alu_ok   = (req.mode == AMD_AM_REG) || ((req.mode == AMD_AM_IMM) && imm_ok && !req.word);
  wire xfer_ok  = (req.mode != AMD_AM_PCREL) && (req.mode != AMD_AM_MEMIND) &&
                  !(short_abs && req.word) &&
                  !(sp_incdec && !req.word) &&
                  !((req.mode == AMD_AM_INCDEC) && (req.sub == AMD_SUB_NONE));
  wire bit_ok   = ((req.mode == AMD_AM_REG) || (req.mode == AMD_AM_IND) || (req.mode == AMD_AM_ABS)) &&
                  !(req.bit_from_reg && !is_bset4) && !req.word;

  assign legal = (req.op <= AMD_OP_LAST_REAL) &&
                 (is_xfer ? xfer_ok :
                  (is_arith || is_logic || is_shift) ? alu_ok :
                  is_bit ? bit_ok : 1'b1);

endmodule
`default_nettype wire

// File: src/amd_ea_form.sv
`timescale 1ns/1ps
`default_nettype none
module amd_ea_form
  import amd_pkg::*;
(
  input  wire amd_req_t          req,  // Canonical request
  output logic [ADDR_W-1:0]      ea    // Effective address
);

  wire [ADDR_W-1:0] short_ea = {SHORT_ABS_UPPER, req.addr_raw[7:0]};
  wire [ADDR_W-1:0] mind_ea  = {MEM_IND_UPPER, req.addr_raw[7:0]};
  wire              evenize  = req.word || (req.mode == AMD_AM_MEMIND) || (req.op == AMD_OP_JUMP_OP) ||
                               (req.op == AMD_OP_JUMP_SUBROUTINE);
  wire [ADDR_W-1:0] raw_sel  = ((req.mode == AMD_AM_ABS) && (req.sub == AMD_SUB_SHORT)) ? short_ea :
                               (req.mode == AMD_AM_MEMIND) ? mind_ea : req.addr_raw;

  assign ea = {raw_sel[ADDR_W-1:1], raw_sel[0] & ~evenize};

endmodule
`default_nettype wire

// File: verif/cpu_addressing_mode_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_addressing_mode_decoder_tb_top
  import amd_pkg::*;
;
  logic     sys_clk;
  logic     sys_rst;
  logic     req_valid;
  amd_req_t req_in;
  amd_dec_t dec_out;
  logic     dec_valid;
  int       num_errors;
  int       checks_done;

  amd_decoder i_amd_decoder (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .req_valid (req_valid),
    .req_in    (req_in),
    .dec_out   (dec_out),
    .dec_valid (dec_valid)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic amd_req_t mk(input amd_op_t op, input amd_mode_t md, input amd_sub_t sb,
                                  input logic wd, input logic [15:0] ad);
    amd_req_t r;
    r = '0;
    r.op = op;
    r.mode = md;
    r.sub = sb;
    r.word = wd;
    r.addr_raw = ad;
    return r;
  endfunction

  // One request, one cycle later the result must be flagged
  task automatic send(input amd_req_t r);
    @(posedge sys_clk);
    req_in <= r;
    req_valid <= 1'b1;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    chk(dec_valid, 1'b1);
  endtask

  task automatic legal(input amd_op_t op, input amd_mode_t md, input amd_sub_t sb, input logic wd,
                       input logic inv);
    send(mk(op, md, sb, wd, 16'h0010));
    chk(dec_out.invalid, inv);
  endtask

  task automatic test_alu();
    amd_op_t ops[7] = '{AMD_OP_ADD, AMD_OP_ADD_WITH_CARRY, AMD_OP_SUBTRACT_WITH_CARRY, AMD_OP_CMP,
                        AMD_OP_AND, AMD_OP_OR, AMD_OP_XOR};
    legal(AMD_OP_ADD, AMD_AM_REG, AMD_SUB_NONE, 1'b0, 1'b0);
    legal(AMD_OP_NEG, AMD_AM_IND, AMD_SUB_NONE, 1'b0, 1'b1);
    legal(AMD_OP_NOT, AMD_AM_IMM, AMD_SUB_NONE, 1'b0, 1'b1);
    legal(AMD_OP_SUB, AMD_AM_IMM, AMD_SUB_NONE, 1'b0, 1'b1);
    foreach (ops[i]) legal(ops[i], AMD_AM_IMM, AMD_SUB_NONE, 1'b0, 1'b0);
    legal(AMD_OP_ADD, AMD_AM_IMM, AMD_SUB_NONE, 1'b1, 1'b1);
    legal(AMD_OP_ROTATE_LEFT, AMD_AM_ABS, AMD_SUB_NONE, 1'b0, 1'b1);
  endtask

  task automatic test_xfer();
    for (int m = 1; m <= 8; m++) begin
      legal(AMD_OP_GENERAL_TRANSFER, amd_mode_t'(m), (m == 4) ? AMD_SUB_PRE : AMD_SUB_NONE, 1'b0,
            m >= 7);
    end
    legal(AMD_OP_GENERAL_TRANSFER, AMD_AM_INCDEC, AMD_SUB_POST, 1'b1, 1'b0);
    legal(AMD_OP_GENERAL_TRANSFER, AMD_AM_ABS, AMD_SUB_SHORT, 1'b1, 1'b1);
    legal(AMD_OP_GENERAL_TRANSFER, AMD_AM_ABS, AMD_SUB_SHORT, 1'b0, 1'b0);
    send(mk(AMD_OP_GENERAL_TRANSFER, AMD_AM_ABS, AMD_SUB_SHORT, 1'b0, 16'h1242));
    chk(dec_out.ea, {SHORT_ABS_UPPER, 8'h42});
    send(mk(AMD_OP_GENERAL_TRANSFER, AMD_AM_ABS, AMD_SUB_NONE, 1'b1, 16'h1235));
    chk(dec_out.ea, 16'h1234);
    send(mk(AMD_OP_GENERAL_TRANSFER, AMD_AM_ABS, AMD_SUB_NONE, 1'b0, 16'h1235));
    chk(dec_out.ea, 16'h1235);
    send(mk(AMD_OP_JUMP_OP, AMD_AM_MEMIND, AMD_SUB_NONE, 1'b0, 16'h7733));
    chk(dec_out.ea, 16'h0032);
  endtask

  task automatic test_bit();
    amd_req_t r;
    for (int m = 1; m <= 5; m++) begin
      legal(AMD_OP_BIT_SET_OP, amd_mode_t'(m), AMD_SUB_NONE, 1'b0, !(m == 1 || m == 2 || m == 5));
    end
    r = mk(AMD_OP_BAND, AMD_AM_IND, AMD_SUB_NONE, 1'b0, 16'h0010);
    r.bit_imm = 3'h5;
    send(r);
    chk(dec_out.bit_imm, 3'h5);
    for (int c = 6'h1b; c <= 6'h1f; c++) begin
      r = mk(amd_op_t'(c), AMD_AM_REG, AMD_SUB_NONE, 1'b0, 16'h0010);
      r.bit_from_reg = 1'b1;
      send(r);
      chk(dec_out.invalid, c == 6'h1f);
      chk(dec_out.bit_from_reg, 1'b1);
    end
    legal(AMD_OP_BIT_TEST_OP, AMD_AM_REG, AMD_SUB_NONE, 1'b1, 1'b1);
  endtask

  task automatic test_stack();
    amd_req_t r;
    for (int k = 0; k < 2; k++) begin
      send(mk(k ? AMD_OP_POP_ALIAS : AMD_OP_PUSH_ALIAS, AMD_AM_REG, AMD_SUB_NONE, 1'b0, 16'h0000));
      chk({dec_out.op, dec_out.mode, dec_out.word, dec_out.reg_idx, dec_out.invalid},
          {AMD_OP_GENERAL_TRANSFER, AMD_AM_INCDEC, 1'b1, STACK_REG_IDX, 1'b0});
      chk(dec_out.sub, k ? AMD_SUB_POST : AMD_SUB_PRE);
      for (int w = 0; w < 2; w++) begin
        r = mk(AMD_OP_GENERAL_TRANSFER, AMD_AM_INCDEC, k ? AMD_SUB_POST : AMD_SUB_PRE, w[0], 16'h0010);
        r.reg_idx = STACK_REG_IDX;
        send(r);
        chk(dec_out.invalid, !w[0]);
      end
    end
  endtask

  task automatic test_groups();
    int n[8];
    amd_req_t r;
    n = '{default: 0};
    for (int c = 0; c < INSN_TOTAL; c++) begin
      send(mk(amd_op_t'(c), AMD_AM_REG, AMD_SUB_NONE, 1'b0, 16'h0010));
      chk(dec_out.invalid, 1'b0);
      n[dec_out.group]++;
      chk(dec_out.group, c == 0 ? 3'h0 : c <= 6'h0e ? 3'h1 : c <= 6'h12 ? 3'h2 : c <= 6'h1a ? 3'h3 :
          c <= 6'h28 ? 3'h4 : c <= 6'h2d ? 3'h5 : c <= 6'h35 ? 3'h6 : 3'h7);
    end
    chk(n[AMD_GRP_SHIFT], SHIFT_COUNT);
    chk(n[AMD_GRP_BRAN], BRANCH_COUNT);
    chk(n[AMD_GRP_SYS], SYSCTL_COUNT);
    legal(amd_op_t'(6'h39), AMD_AM_REG, AMD_SUB_NONE, 1'b0, 1'b1);
    r = mk(AMD_OP_COND_BRANCH, AMD_AM_PCREL, AMD_SUB_NONE, 1'b0, 16'h0010);
    r.cond = 4'ha;
    send(r);
    chk(dec_out.cond, 4'ha);
    r.op = AMD_OP_NOP;
    send(r);
    chk(dec_out.cond, 4'h0);
  endtask

  // Back-to-back requests, then a reset in mid-run
  task automatic test_timing();
    @(posedge sys_clk);
    req_in <= mk(AMD_OP_INC, AMD_AM_REG, AMD_SUB_NONE, 1'b0, 16'h0010);
    req_valid <= 1'b1;
    @(posedge sys_clk);
    req_in <= mk(AMD_OP_DEC, AMD_AM_REG, AMD_SUB_NONE, 1'b0, 16'h0010);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    chk({dec_valid, dec_out.op}, {1'b1, AMD_OP_DEC});
    @(posedge sys_clk);
    #1;
    chk({dec_valid, dec_out.op}, {1'b0, AMD_OP_DEC});
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk({dec_valid, dec_out}, '0);
  endtask

  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_in = '0;
    num_errors = 0;
    checks_done = 0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk({dec_valid, dec_out}, '0);
    test_alu();
    test_xfer();
    test_bit();
    test_stack();
    test_groups();
    test_timing();
    tally_and_finish();
  end

  // About 220 cycles are needed; a hang is cut off well beyond that
  initial begin
    #(50 * 4000);
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
